// ==== rtl/gpio_port.sv ====
// How it works
// [RULE_01] eight bidirectional pins, each general-purpose input/output
// [RULE_02] output value register drives pins, resets zero
// [RULE_03] output pins read back the written value
// [RULE_04] input pins read back their sampled level
// [RULE_05] direction register: zero output, one input
// [RULE_06] output drive: hi-z, p open drain, n, push-pull
// [RULE_07] input: floating, pull-down or pull-up
// [RULE_08] two drive registers, first also as word
// [RULE_09] two function registers, first also as word
// [RULE_10] pins switch to bus, serial, pulse functions
// [RULE_11] software leaves analog pins as hi-z outputs
// [RULE_12] drive code decode differs by direction
// [RULE_13] function code decode: gpio, second, third, fourth
// [RULE_14] prohibited code ignores value, hi-z or low
// [RULE_15] serial outputs forced to push-pull
// [RULE_16] after reset all pins hi-z outputs
// [RULE_17] word access: lower address is low byte
`timescale 1ns/1ps
`include "gpio_port_consts.svh"

module gpio_port
    import gpio_port_pkg::*;
(
    // clock, reset, enable
    input  wire logic        CORE_CLK_I,
    input  wire logic        RST_N_I,
    input  wire logic        CE_I,
    // axi4-lite write address and data
    input  wire logic        AWVALID_I,
    output logic             AWREADY_O,
    input  wire logic [31:0] AWADDR_I,
    input  wire logic [2:0]  AWPROT_I,
    input  wire logic        WVALID_I,
    output logic             WREADY_O,
    input  wire logic [31:0] WDATA_I,
    input  wire logic [3:0]  WSTRB_I,
    // axi4-lite write response
    output logic             BVALID_O,
    input  wire logic        BREADY_I,
    output logic [1:0]       BRESP_O,
    // axi4-lite read
    input  wire logic        ARVALID_I,
    output logic             ARREADY_O,
    input  wire logic [31:0] ARADDR_I,
    input  wire logic [2:0]  ARPROT_I,
    output logic             RVALID_O,
    input  wire logic        RREADY_I,
    output logic [31:0]      RDATA_O,
    output logic [1:0]       RRESP_O,
    // pads
    input  wire logic [7:0]  PIN_IN_I,
    output logic [7:0]       PIN_OUT_O,
    output logic [7:0]       PIN_OE_O,
    output logic [7:0]       PULL_UP_O,
    output logic [7:0]       PULL_DOWN_O,
    // peripheral signals heading to the pins
    input  wire logic        BUS_DATA_OUT_I,
    input  wire logic        BUS_CLK_OUT_I,
    input  wire logic        CLOCKED_SERIAL_OUT_I,
    input  wire logic        CLOCKED_SERIAL_CLK_I,
    input  wire logic        CLOCKED_SERIAL_CLK_DRIVE_I,
    input  wire logic        ASYNC_A_TRANSMIT_I,
    input  wire logic        ASYNC_B_TRANSMIT_I,
    input  wire logic        PULSE_OUT_A_I,
    input  wire logic        PULSE_OUT_B_I,
    // pin levels heading to the peripherals
    output logic             BUS_DATA_IN_O,
    output logic             BUS_CLK_IN_O,
    output logic             CLOCKED_SERIAL_IN_O,
    output logic             CLOCKED_SERIAL_CLK_IN_O,
    output logic             ASYNC_A_RECEIVE_O
);

    port_state_t s;
    port_state_t next_s;

    logic [8:0]  alt_src;
    pin_route_t  route [8];
    logic [7:0]  drv_out;
    logic [7:0]  drv_oe;
    logic [7:0]  drv_pu;
    logic [7:0]  drv_pd;
    logic [7:0]  read_val;
    logic [15:0] rd_word;
    logic        rd_ok;
    logic        ar_top_ok;

    // peripheral outputs packed for the routing table
    assign alt_src = {PULSE_OUT_B_I, PULSE_OUT_A_I, ASYNC_B_TRANSMIT_I,
                      ASYNC_A_TRANSMIT_I, CLOCKED_SERIAL_CLK_DRIVE_I,
                      CLOCKED_SERIAL_CLK_I, CLOCKED_SERIAL_OUT_I,
                      BUS_CLK_OUT_I, BUS_DATA_OUT_I};

    // pin and function code to routing; unlisted codes are prohibited
    function automatic pin_route_t route_of(input int unsigned pin,
                                            input logic [1:0]  fn,
                                            input logic [8:0]  src);
        pin_route_t r;
        r.kind  = PK_BLOCKED;
        r.data  = 1'b0;
        r.drive = 1'b1;
        if (fn == `FN_GPIO) begin
            r.kind = PK_GPIO;                             // [RULE_13]
        end else begin
            case (pin)
                0: begin
                    if (fn == `FN_SECOND) begin
                        r.kind = PK_ALT_OUT;              // [RULE_10]
                        r.data = src[0];
                    end else if (fn == `FN_THIRD) begin
                        r.kind = PK_ALT_IN;
                    end
                end
                1: begin
                    if (fn == `FN_SECOND) begin
                        r.kind = PK_ALT_OUT;              // [RULE_10]
                        r.data = src[1];
                    end else if (fn == `FN_THIRD) begin
                        r.kind  = PK_ALT_PUSH;            // [RULE_15]
                        r.data  = src[3];
                        r.drive = src[4];
                    end
                end
                2: begin
                    if (fn == `FN_SECOND) begin
                        r.kind = PK_ALT_IN;               // [RULE_10]
                    end else if (fn == `FN_THIRD) begin
                        r.kind = PK_ALT_PUSH;             // [RULE_15]
                        r.data = src[2];
                    end
                end
                3: begin
                    if (fn == `FN_SECOND) begin
                        r.kind = PK_ALT_PUSH;             // [RULE_15]
                        r.data = src[5];
                    end else if (fn == `FN_THIRD) begin
                        r.kind = PK_ALT_OUT;              // [RULE_10]
                        r.data = src[7];
                    end else begin
                        r.kind = PK_ALT_PUSH;             // [RULE_15]
                        r.data = src[6];
                    end
                end
                4: begin
                    if (fn == `FN_THIRD) begin
                        r.kind = PK_ALT_IN;               // [RULE_10]
                    end
                end
                5: begin
                    if (fn == `FN_THIRD) begin
                        r.kind  = PK_ALT_PUSH;            // [RULE_15]
                        r.data  = src[3];
                        r.drive = src[4];
                    end
                end
                6: begin
                    if (fn == `FN_THIRD) begin
                        r.kind = PK_ALT_PUSH;             // [RULE_15]
                        r.data = src[2];
                    end
                end
                default: begin
                    if (fn == `FN_THIRD) begin
                        r.kind = PK_ALT_OUT;              // [RULE_10]
                        r.data = src[8];
                    end
                end
            endcase
        end
        return r;
    endfunction

    // one routing decode and pad driver per pin
    for (genvar i = 0; i < 8; i++) begin : g_pin
        assign route[i] = route_of(i, {s.fn_hi[i], s.fn_lo[i]}, alt_src);
        assign read_val[i] = s.dir[i] ? s.pin_level[i]  // [RULE_04]
                                      : s.out_val[i];   // [RULE_03]
        pin_driver u_drv (
            .dir_i      (s.dir[i]),
            .cfg_i      ({s.cfg_hi[i], s.cfg_lo[i]}),
            .route_i    (route[i]),
            .port_bit_i (s.out_val[i]),
            .out_o      (drv_out[i]),
            .oe_o       (drv_oe[i]),
            .pull_up_o  (drv_pu[i]),
            .pull_dn_o  (drv_pd[i])
        );                                                // [RULE_01]
    end

    // read decode; pairs read as a word with the lower address low
    assign ar_top_ok = (ARADDR_I[31:`ADDR_TOP_LSB] == 14'h0000);
    always_comb begin
        rd_ok   = ar_top_ok;
        rd_word = 16'h0000;
        case (ARADDR_I[`IDX_MSB:`IDX_LSB])
            `IDX_OUTPUT_VALUE: rd_word = {8'h00, read_val};
            `IDX_DIRECTION:    rd_word = {8'h00, s.dir};
            `IDX_DRIVE_LO:     rd_word = {s.cfg_hi, s.cfg_lo}; // [RULE_17]
            `IDX_DRIVE_HI:     rd_word = {8'h00, s.cfg_hi};
            `IDX_FUNC_LO:      rd_word = {s.fn_hi, s.fn_lo};   // [RULE_17]
            `IDX_FUNC_HI:      rd_word = {8'h00, s.fn_hi};
            default:           rd_ok   = 1'b0;
        endcase
        if (!rd_ok) begin
            rd_word = 16'h0000;
        end
    end

    // next state: bus slave, register writes, pad and peripheral outputs
    always_comb begin
        next_s = s;
        next_s.pin_level = PIN_IN_I;         // pins are already synchronous
        // address and data are taken independently, in either order
        if (AWVALID_I && s.awready) begin
            next_s.aw_full = 1'b1;
            next_s.aw_idx  = AWADDR_I[`IDX_MSB:`IDX_LSB];
            next_s.aw_ok   = (AWADDR_I[31:`ADDR_TOP_LSB] == 14'h0000);
        end
        if (WVALID_I && s.wready) begin
            next_s.w_full = 1'b1;
            next_s.w_data = WDATA_I[15:0];
            next_s.w_strb = WSTRB_I[1:0];
        end
        if (s.bvalid && BREADY_I) begin
            next_s.bvalid = 1'b0;
        end
        // commit once both halves are held and the old response is gone
        if (s.aw_full && s.w_full && !s.bvalid) begin
            next_s.aw_full = 1'b0;
            next_s.w_full  = 1'b0;
            next_s.bvalid  = 1'b1;
            next_s.bresp   = `RESP_OKAY;
            if (!s.aw_ok) begin
                next_s.bresp = `RESP_SLVERR;
            end else begin
                case (s.aw_idx)
                    `IDX_OUTPUT_VALUE: begin
                        if (s.w_strb[0]) begin
                            next_s.out_val = s.w_data[7:0];  // [RULE_02]
                        end
                    end
                    `IDX_DIRECTION: begin
                        if (s.w_strb[0]) begin
                            next_s.dir = s.w_data[7:0];      // [RULE_05]
                        end
                    end
                    `IDX_DRIVE_LO: begin
                        if (s.w_strb[0]) begin
                            next_s.cfg_lo = s.w_data[7:0];   // [RULE_08]
                        end
                        if (s.w_strb[1]) begin
                            next_s.cfg_hi = s.w_data[15:8];  // [RULE_17]
                        end
                    end
                    `IDX_DRIVE_HI: begin
                        if (s.w_strb[0]) begin
                            next_s.cfg_hi = s.w_data[7:0];   // [RULE_08]
                        end
                    end
                    `IDX_FUNC_LO: begin
                        if (s.w_strb[0]) begin
                            next_s.fn_lo = s.w_data[7:0];    // [RULE_09]
                        end
                        if (s.w_strb[1]) begin
                            next_s.fn_hi = s.w_data[15:8];   // [RULE_17]
                        end
                    end
                    `IDX_FUNC_HI: begin
                        if (s.w_strb[0]) begin
                            next_s.fn_hi = s.w_data[7:0];    // [RULE_09]
                        end
                    end
                    default: next_s.bresp = `RESP_SLVERR;
                endcase
            end
        end
        // a channel is ready only while its holding slot is empty
        next_s.awready = ~next_s.aw_full;
        next_s.wready  = ~next_s.w_full;
        // one read at a time; data captured with the address
        if (s.rvalid && RREADY_I) begin
            next_s.rvalid = 1'b0;
        end
        if (ARVALID_I && s.arready) begin
            next_s.rvalid = 1'b1;
            next_s.rdata  = rd_word;
            next_s.rresp  = rd_ok ? `RESP_OKAY : `RESP_SLVERR;
        end
        next_s.arready = ~next_s.rvalid;
        // pad controls are registered so outputs leave flip-flops
        next_s.pin_out = drv_out;
        next_s.pin_oe  = drv_oe;
        next_s.pull_up = drv_pu;
        next_s.pull_dn = drv_pd;
        // peripheral inputs idle high when no pin carries them
        next_s.per_in = 5'h1f;
        if (route[0].kind == PK_ALT_OUT) begin
            next_s.per_in[0] = s.pin_level[0];   // bus data reads back pad
        end
        if (route[1].kind == PK_ALT_OUT) begin
            next_s.per_in[1] = s.pin_level[1];
        end
        if (route[0].kind == PK_ALT_IN) begin
            next_s.per_in[2] = s.pin_level[0];
        end else if (route[4].kind == PK_ALT_IN) begin
            next_s.per_in[2] = s.pin_level[4];
        end
        if (route[1].kind == PK_ALT_PUSH) begin
            next_s.per_in[3] = s.pin_level[1];
        end else if (route[5].kind == PK_ALT_PUSH) begin
            next_s.per_in[3] = s.pin_level[5];
        end
        if (route[2].kind == PK_ALT_IN) begin
            next_s.per_in[4] = s.pin_level[2];
        end
    end

    // all registers zero on reset except per_in, which resets high: hi-z outputs, gpio mode
    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            s        <= '0;                               // [RULE_16]
            s.per_in <= 5'h1f;
        end else if (CE_I) begin
            s <= next_s;
        end
    end

    // outputs straight from the state register
    assign AWREADY_O               = s.awready;
    assign WREADY_O                = s.wready;
    assign BVALID_O                = s.bvalid;
    assign BRESP_O                 = s.bresp;
    assign ARREADY_O               = s.arready;
    assign RVALID_O                = s.rvalid;
    assign RDATA_O                 = {16'h0000, s.rdata};
    assign RRESP_O                 = s.rresp;
    assign PIN_OUT_O               = s.pin_out;
    assign PIN_OE_O                = s.pin_oe;
    assign PULL_UP_O               = s.pull_up;
    assign PULL_DOWN_O             = s.pull_dn;
    assign BUS_DATA_IN_O           = s.per_in[0];
    assign BUS_CLK_IN_O            = s.per_in[1];
    assign CLOCKED_SERIAL_IN_O     = s.per_in[2];
    assign CLOCKED_SERIAL_CLK_IN_O = s.per_in[3];
    assign ASYNC_A_RECEIVE_O       = s.per_in[4];

endmodule // gpio_port

// ==== rtl/gpio_port_consts.svh ====
`ifndef GPIO_PORT_CONSTS_SVH
`define GPIO_PORT_CONSTS_SVH

// register indices; the byte address on the bus is four times the index
`define IDX_OUTPUT_VALUE 16'hf220
`define IDX_DIRECTION    16'hf221
`define IDX_DRIVE_LO     16'hf222
`define IDX_DRIVE_HI     16'hf223
`define IDX_FUNC_LO      16'hf224
`define IDX_FUNC_HI      16'hf225

// index field inside the byte address, and the bits above it
`define IDX_LSB          2
`define IDX_MSB          17
`define ADDR_TOP_LSB     18

// reset value of every port register
`define REG_RESET        8'h00

// bus responses
`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10

// function select codes
`define FN_GPIO          2'b00
`define FN_SECOND        2'b01
`define FN_THIRD         2'b10
`define FN_FOURTH        2'b11

// drive configuration codes
`define DRV_HIZ          2'b00
`define DRV_PCH          2'b01
`define DRV_NCH          2'b10
`define DRV_PUSH         2'b11

`endif

// ==== rtl/gpio_port_pkg.sv ====
package gpio_port_pkg;

    // what a pin is doing after function select decode
    typedef enum logic [2:0] {
        PK_GPIO     = 3'b000,
        PK_ALT_OUT  = 3'b001,
        PK_ALT_PUSH = 3'b010,
        PK_ALT_IN   = 3'b011,
        PK_BLOCKED  = 3'b100
    } pin_kind_t;

    // decoded routing of one pin
    typedef struct packed {
        pin_kind_t kind;
        logic      data;
        logic      drive;
    } pin_route_t;

    // whole state of the port
    typedef struct packed {
        logic [7:0]  out_val;
        logic [7:0]  dir;
        logic [7:0]  cfg_lo;
        logic [7:0]  cfg_hi;
        logic [7:0]  fn_lo;
        logic [7:0]  fn_hi;
        logic [7:0]  pin_level;
        logic [7:0]  pin_out;
        logic [7:0]  pin_oe;
        logic [7:0]  pull_up;
        logic [7:0]  pull_dn;
        logic [4:0]  per_in;
        logic        aw_full;
        logic        aw_ok;
        logic [15:0] aw_idx;
        logic        w_full;
        logic [15:0] w_data;
        logic [1:0]  w_strb;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [15:0] rdata;
        logic [1:0]  rresp;
    } port_state_t;

endpackage

// ==== rtl/pin_driver.sv ====
`timescale 1ns/1ps
`include "gpio_port_consts.svh"

module pin_driver
    import gpio_port_pkg::*;
(
    // configuration of this pin
    input  wire logic       dir_i,
    input  wire logic [1:0] cfg_i,
    input  wire pin_route_t route_i,
    input  wire logic       port_bit_i,
    // next pin controls
    output logic            out_o,
    output logic            oe_o,
    output logic            pull_up_o,
    output logic            pull_dn_o
);

    logic       data;
    logic [1:0] style;

    // pick the level and drive style, then the pad controls
    always_comb begin
        data      = port_bit_i;
        style     = cfg_i;
        out_o     = 1'b0;
        oe_o      = 1'b0;
        pull_up_o = 1'b0;
        pull_dn_o = 1'b0;
        unique case (route_i.kind)
            PK_GPIO:     data = port_bit_i;
            PK_ALT_OUT:  data = route_i.data;
            PK_ALT_PUSH: begin
                data  = route_i.data;
                style = `DRV_PUSH;                        // [RULE_15]
            end
            PK_ALT_IN:   data = 1'b0;
            // forcing low gives hi-z for pch, low for nch and push-pull
            PK_BLOCKED:  data = 1'b0;                     // [RULE_14]
            default:     data = 1'b0;
        endcase
        if (dir_i || route_i.kind == PK_ALT_IN) begin
            // input mode: 11 floats like 00
            pull_dn_o = (cfg_i == `DRV_PCH);              // [RULE_07] [RULE_12]
            pull_up_o = (cfg_i == `DRV_NCH);              // [RULE_07] [RULE_12]
        end else if (route_i.drive) begin
            unique case (style)
                `DRV_HIZ: oe_o = 1'b0;                    // [RULE_06] [RULE_12]
                `DRV_PCH: begin
                    oe_o  = data;                         // [RULE_06]
                    out_o = 1'b1;
                end
                `DRV_NCH: begin
                    oe_o  = ~data;                        // [RULE_06]
                    out_o = 1'b0;
                end
                `DRV_PUSH: begin
                    oe_o  = 1'b1;                         // [RULE_06]
                    out_o = data;                         // [RULE_02]
                end
            endcase
        end
    end

endmodule // pin_driver

// ==== verif/eight_bit_io_port_tb.sv ====
`timescale 1ns/1ps
`include "gpio_port_consts.svh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
    mismatches++; $display("Error %s exp %h got %h", n, e, g); end end
module eight_bit_io_port_tb;
    // bus and pad stimulus
    logic        clk = 1'b0, rst_n = 1'b0;
    logic        awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
    logic [31:0] awa = 32'h0, wd = 32'h0, ara = 32'h0, rd;
    logic [3:0]  ws = 4'h0, pfb;
    logic [8:0]  per = 9'h000;
    logic [7:0]  ev = 8'h00, ee = 8'h00, lvl, po, poe, pu, pd;
    logic [1:0]  br, rr;
    logic        awr, wrdy, bv, arr, rv, recv;
    int          mismatches = 0, checks_done = 0;
    logic [7:0]  xoe [4] = '{8'h00, 8'ha5, 8'h5a, 8'hff};
    logic [7:0]  xout [4] = '{8'h00, 8'ha5, 8'h00, 8'ha5};

    always #4 clk = ~clk;

    gpio_port gpio_port_i (.CORE_CLK_I(clk), .RST_N_I(rst_n), .CE_I(1'b1),
        .AWVALID_I(awv), .AWREADY_O(awr), .AWADDR_I(awa), .AWPROT_I(3'h0),
        .WVALID_I(wv), .WREADY_O(wrdy), .WDATA_I(wd), .WSTRB_I(ws),
        .BVALID_O(bv), .BREADY_I(bre), .BRESP_O(br), .ARVALID_I(arv),
        .ARREADY_O(arr), .ARADDR_I(ara), .ARPROT_I(3'h0), .RVALID_O(rv),
        .RREADY_I(rre), .RDATA_O(rd), .RRESP_O(rr), .PIN_IN_I(lvl),
        .PIN_OUT_O(po), .PIN_OE_O(poe), .PULL_UP_O(pu), .PULL_DOWN_O(pd),
        .BUS_DATA_OUT_I(per[0]), .BUS_CLK_OUT_I(per[1]),
        .CLOCKED_SERIAL_OUT_I(per[2]), .CLOCKED_SERIAL_CLK_I(per[3]),
        .CLOCKED_SERIAL_CLK_DRIVE_I(per[4]), .ASYNC_A_TRANSMIT_I(per[5]),
        .ASYNC_B_TRANSMIT_I(per[6]), .PULSE_OUT_A_I(per[7]),
        .PULSE_OUT_B_I(per[8]), .BUS_DATA_IN_O(pfb[0]),
        .BUS_CLK_IN_O(pfb[1]), .CLOCKED_SERIAL_IN_O(pfb[2]),
        .CLOCKED_SERIAL_CLK_IN_O(pfb[3]), .ASYNC_A_RECEIVE_O(recv));

    pad_world pad_world_i (.clk_i(clk), .out_i(po), .oe_i(poe), .up_i(pu),
        .dn_i(pd), .ext_val_i(ev), .ext_en_i(ee), .level_o(lvl));

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // address and data offered together; bready stays up
    task automatic bus_wr(input logic [15:0] i, input logic [15:0] d,
                          input logic [1:0] s, input logic [1:0] er);
        int t;
        t = 0;
        awa <= {14'h0, i, 2'b00};
        wd <= {16'h0, d};
        ws <= {2'b00, s};
        awv <= 1'b1;
        wv <= 1'b1;
        bre <= 1'b1;
        do begin
            @(posedge clk);
            t++;
            if (awr) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
        end while (!bv && t < 50);
        if (!bv) mismatches++;
        if (!bv) wrap_up();
        `CHK("bresp", er, br)
        @(posedge clk);
    endtask

    task automatic rchk(input string n, input logic [15:0] i,
                        input logic [31:0] e, input logic [1:0] er);
        int t;
        t = 0;
        ara <= {14'h0, i, 2'b00};
        arv <= 1'b1;
        rre <= 1'b1;
        do begin
            @(posedge clk);
            t++;
            if (arr) arv <= 1'b0;
        end while (!rv && t < 50);
        if (!rv) mismatches++;
        if (!rv) wrap_up();
        `CHK(n, e, rd)
        `CHK("rresp", er, rr)
    endtask

    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        // all quiet after reset
        for (int i = 0; i < 6; i++) rchk("rst", 16'hf220 + 16'(i), 32'h0, `RESP_OKAY);
        `CHK("rst_oe", 8'h00, poe | pu | pd)
        `CHK("per_idle", 4'hf, pfb)
        bus_wr(`IDX_OUTPUT_VALUE, 16'h00a5, 2'b01, `RESP_OKAY);
        rchk("outval", `IDX_OUTPUT_VALUE, 32'ha5, `RESP_OKAY);
        // each output drive code, via the word form
        for (int c = 0; c < 4; c++) begin
            bus_wr(`IDX_DRIVE_LO, {{8{c[1]}}, {8{c[0]}}}, 2'b11, `RESP_OKAY);
            `CHK("oe", xoe[c], poe)
            `CHK("out", xout[c], po & xoe[c])
        end
        rchk("cfgword", `IDX_DRIVE_LO, 32'hffff, `RESP_OKAY);
        bus_wr(`IDX_DRIVE_HI, 16'h0000, 2'b01, `RESP_OKAY);
        rchk("cfgword", `IDX_DRIVE_LO, 32'h00ff, `RESP_OKAY);
        bus_wr(`IDX_DIRECTION, 16'h00ff, 2'b01, `RESP_OKAY);
        // input mode: pulls only, never a drive
        for (int c = 0; c < 4; c++) begin
            bus_wr(`IDX_DRIVE_LO, {{8{c[1]}}, {8{c[0]}}}, 2'b11, `RESP_OKAY);
            `CHK("in_oe", 8'h00, poe)
            `CHK("pdn", (c == 1) ? 8'hff : 8'h00, pd)
            `CHK("pup", (c == 2) ? 8'hff : 8'h00, pu)
        end
        ev <= 8'h3c;
        ee <= 8'hff;
        repeat (4) @(posedge clk);
        rchk("pins", `IDX_OUTPUT_VALUE, 32'h3c, `RESP_OKAY);
        bus_wr(`IDX_DIRECTION, 16'h000f, 2'b01, `RESP_OKAY);
        rchk("mixed", `IDX_OUTPUT_VALUE, 32'hac, `RESP_OKAY);
        // pin0 prohibited, pin2 async receive, pin3 async transmit
        bus_wr(`IDX_FUNC_LO, 16'h010d, 2'b11, `RESP_OKAY);
        rchk("fnword", `IDX_FUNC_LO, 32'h010d, `RESP_OKAY);
        bus_wr(`IDX_DIRECTION, 16'h0004, 2'b01, `RESP_OKAY);
        per <= 9'h020;
        repeat (3) @(posedge clk);
        `CHK("proh", 2'b10, {poe[0], po[0]})
        `CHK("tx_a", 2'b11, {poe[3], po[3]})
        `CHK("rx_a", 1'b1, recv)
        ev <= 8'h38;
        per <= 9'h000;
        repeat (3) @(posedge clk);
        `CHK("rx_a", 1'b0, recv)
        `CHK("tx_a", 1'b0, po[3])
        // high impedance drive; pins 4 to 7 stay analog-safe
        bus_wr(`IDX_DRIVE_LO, 16'h0000, 2'b11, `RESP_OKAY);
        `CHK("hiz", 2'b01, {poe[0], poe[3]})
        bus_wr(`IDX_FUNC_HI, 16'h0009, 2'b01, `RESP_OKAY);
        per <= 9'h040;
        repeat (3) @(posedge clk);
        `CHK("tx_b", 2'b11, {poe[3], po[3]})
        bus_wr(`IDX_FUNC_LO, 16'h0005, 2'b01, `RESP_OKAY);
        `CHK("pulse", 1'b0, poe[3])
        bus_wr(`IDX_OUTPUT_VALUE, 16'h00ff, 2'b00, `RESP_OKAY);
        rchk("nostrb", `IDX_OUTPUT_VALUE, 32'ha1, `RESP_OKAY);
        bus_wr(16'hf226, 16'h00ff, 2'b01, `RESP_SLVERR);
        rchk("unmapped", 16'hf226, 32'h0, `RESP_SLVERR);
        wrap_up();
    end
endmodule // eight_bit_io_port_tb

bind gpio_port gpio_port_properties gpio_port_properties_i (.CORE_CLK_I,
    .RST_N_I, .CE_I, .AWVALID_I, .AWREADY_O, .WVALID_I, .WREADY_O,
    .BVALID_O, .BREADY_I, .BRESP_O, .ARVALID_I, .ARREADY_O, .RVALID_O,
    .RREADY_I, .RDATA_O, .PIN_OE_O, .PULL_UP_O, .PULL_DOWN_O,
    .ASYNC_A_RECEIVE_O);

// ==== verif/gpio_port_properties.sv ====
`timescale 1ns/1ps
module gpio_port_properties (
    // clock, reset, enable
    input wire logic       CORE_CLK_I,
    input wire logic       RST_N_I,
    input wire logic       CE_I,
    // register bus
    input wire logic       AWVALID_I,
    input wire logic       AWREADY_O,
    input wire logic       WVALID_I,
    input wire logic       WREADY_O,
    input wire logic       BVALID_O,
    input wire logic       BREADY_I,
    input wire logic [1:0] BRESP_O,
    input wire logic       ARVALID_I,
    input wire logic       ARREADY_O,
    input wire logic       RVALID_O,
    input wire logic       RREADY_I,
    input wire logic [31:0] RDATA_O,
    // pads and peripheral side
    input wire logic [7:0] PIN_OE_O,
    input wire logic [7:0] PULL_UP_O,
    input wire logic [7:0] PULL_DOWN_O,
    input wire logic       ASYNC_A_RECEIVE_O
);
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (!RST_N_I);
    // answer rises at the commit edge, one after the take
    property p_wr_lat; AWVALID_I && AWREADY_O && WVALID_I && WREADY_O &&
        CE_I && !BVALID_O |=> !BVALID_O ##1 BVALID_O; endproperty
    a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
    property p_b_hold; BVALID_O && !BREADY_I |=>
        BVALID_O && $stable(BRESP_O); endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
    property p_b_done; BVALID_O && BREADY_I && CE_I && AWREADY_O &&
        !AWVALID_I |=> !BVALID_O && AWREADY_O; endproperty
    a_b_done: assert property (p_b_done) else $error("write not rearmed");
    property p_r_lat; ARVALID_I && ARREADY_O && CE_I |=>
        RVALID_O && !ARREADY_O; endproperty
    a_r_lat: assert property (p_r_lat) else $error("read answer late");
    property p_r_hold; RVALID_O && !RREADY_I |=>
        RVALID_O && $stable(RDATA_O); endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data moved");
    property p_r_done; RVALID_O && RREADY_I && CE_I |=>
        !RVALID_O && ARREADY_O; endproperty
    a_r_done: assert property (p_r_done) else $error("read not rearmed");
    // first edge out of reset still shows quiet pads
    property p_rst_pads; $rose(RST_N_I) |-> PIN_OE_O == 8'h00 &&
        (PULL_UP_O | PULL_DOWN_O) == 8'h00 && ASYNC_A_RECEIVE_O; endproperty
    a_rst_pads: assert property (p_rst_pads) else $error("pads live after reset");
    property p_pull_excl; (PIN_OE_O & (PULL_UP_O | PULL_DOWN_O)) == 8'h00 &&
        (PULL_UP_O & PULL_DOWN_O) == 8'h00; endproperty
    a_pull_excl: assert property (p_pull_excl) else $error("pull clash");
    c_write: cover property (BVALID_O && BREADY_I);
    c_read: cover property (RVALID_O && RREADY_I);
    c_slverr: cover property (BVALID_O && BRESP_O == 2'b10);
endmodule // gpio_port_properties

// ==== verif/pad_world.sv ====
`timescale 1ns/1ps
module pad_world (
    // pad controls from the port
    input  wire logic       clk_i,
    input  wire logic [7:0] out_i,
    input  wire logic [7:0] oe_i,
    input  wire logic [7:0] up_i,
    input  wire logic [7:0] dn_i,
    // far-side drivers
    input  wire logic [7:0] ext_val_i,
    input  wire logic [7:0] ext_en_i,
    // resolved pad level
    output logic [7:0]      level_o
);
    logic [7:0] last = 8'h00;
    // a floating pad flips each cycle so nothing relies on a held level
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            level_o[i] = oe_i[i] ? out_i[i] : ext_en_i[i] ? ext_val_i[i] :
                up_i[i] ? 1'b1 : dn_i[i] ? 1'b0 : ~last[i];
        end
    end
    always_ff @(posedge clk_i) last <= level_o;
endmodule // pad_world
